// ---- design/lin_tx_pkg.sv ----
// Purpose: Shared constants and types for the serial channel with LIN send
// Assumes: One clock at 40 MHz, synchronous active-low reset
// Notes:   Field positions of the status word are used by the flag clear port
//
// Functional notes
// - Status word reports parity, overflow and framing errors as separate flags.
// - Flag clear write clears exactly the error flags whose bits are one.
// - Writing the stop bit drops the enable status and halts the channel.
// - Writing the start bit sets enable status and makes the channel operational.
// - LIN send exists only on channel zero of unit zero, its transmit pin.
// - Transmit interrupt: end of transfer (single) or buffer empty (continuous).
// - Frames: 8 data bits LSB first, no parity, one stop bit; no error flag.
// - Bit rate at most channel clock over 6, divider at least 2.
// - Transmit output normal phase idling high or inverted idling low.
// - Single-mode transmit interrupt at end of every byte, the break field included.
package lin_tx_pkg;

	localparam int DATA_W      = 8;
	localparam int FIFO_DEPTH  = 32;
	localparam int DIV_W       = 7;
	localparam int PRE_W       = 4;
	localparam int PRE_CNT_W   = 15;
	localparam int BIT_CNT_W   = 9;
	localparam logic [DIV_W-1:0] DIV_MIN   = 7'h02;
	localparam logic [DIV_W-1:0] DIV_RESET = 7'h67;
	localparam logic [PRE_W-1:0] PRE_RESET = 4'h0;
	localparam int CLK_HZ      = 40000000;

	localparam int ERR_PARITY  = 0;
	localparam int ERR_OVERRUN = 1;
	localparam int ERR_FRAMING = 2;
	localparam int ERR_W       = 3;

	typedef struct packed {
		logic             txBusy;
		logic             bufferFullFlag;
		logic [ERR_W-1:0] errFlags;
	} channel_status_t;

	typedef struct packed {
		logic [DIV_W-1:0] divider;
		logic [PRE_W-1:0] preSel;
		logic             invertOut;
		logic             contMode;
		logic             parityEn;
	} channel_cfg_t;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_START = 2'b01,
		TX_DATA  = 2'b10,
		TX_STOP  = 2'b11
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE   = 2'b00,
		RX_START  = 2'b01,
		RX_DATA   = 2'b10,
		RX_STOP   = 2'b11
	} rx_state_t;

endpackage

// ---- design/sync_fifo.sv ----
// Purpose: Synchronous FIFO with valid and ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes:   inReady is registered so it can leave the top directly
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             inValid,
	output var  logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	output var  logic             outValid,
	input  wire logic             outReady,
	output var  logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	logic             push;
	logic             pop;

	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outValid = (count_r != '0);
	assign outData = mem[rdPtr_r];

	always_comb begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + 1'b1;
		end else if (pop && !push) begin
			count_nxt = count_r - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
			inReady <= 1'b0;
		end else begin
			if (push) begin
				wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
			end
			count_r <= count_nxt;
			inReady <= (count_nxt != (AW+1)'(DEPTH));
		end
	end

	a_no_overfill: assert property (@(posedge clk) disable iff (!rst_n)
		count_r <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");

endmodule // sync_fifo
`default_nettype wire

// ---- design/uart_lin_tx.sv ----
// Purpose: One serial channel: LIN-capable send, receive, error recovery
// Assumes: Pins synchronous to clk; software strobes are one-cycle pulses
// Notes:   Bit period is 2*(divider+1) channel clocks; channel clock clk/2^preSel
`timescale 1ns/100ps
`default_nettype none
module uart_lin_tx
	import lin_tx_pkg::*;
#(
	parameter int FIFO_W = DATA_W,
	parameter int FIFO_D = FIFO_DEPTH
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                txWrite,
	input  wire logic [DATA_W-1:0]   txData,
	output var  logic                txReady,
	input  wire logic                dataRead,
	output var  logic [DATA_W-1:0]   channelDataReg,
	output var  channel_status_t     channelStatusReg,
	input  wire logic                flagClearWrite,
	input  wire logic [ERR_W-1:0]    flagClearValue,
	input  wire logic                channelStopBit,
	input  wire logic                channelStartBit,
	output var  logic                channelEnableStatusBit,
	input  wire channel_cfg_t        cfgIn,
	output var  channel_cfg_t        cfgActive,
	output var  logic                transmitIrq,
	output var  logic                serialTxPin,
	input  wire logic                serialRxPin
);
	////////////////////////////////////////////////////////////////////////////
	// Prescaler and bit timing

	function automatic logic preHit(input logic [PRE_CNT_W-1:0] cnt,
		input logic [PRE_W-1:0] sel);
		logic [PRE_CNT_W-1:0] mask;
		mask = PRE_CNT_W'((32'h1 << sel) - 32'h1);
		return (cnt & mask) == mask;
	endfunction

	function automatic logic [BIT_CNT_W-1:0] bitLen(input logic [DIV_W-1:0] d);
		return {1'b0, d, 1'b0} + 9'h002;
	endfunction

	channel_cfg_t            cfg_r;
	logic [PRE_CNT_W-1:0]    preCnt_r;
	logic                    mckEn;
	logic                    enable_r;
	logic [BIT_CNT_W-1:0]    bitPeriod;

	assign mckEn = preHit(preCnt_r, cfg_r.preSel);
	assign bitPeriod = bitLen(cfg_r.divider);
	assign channelEnableStatusBit = enable_r;
	assign cfgActive = cfg_r;

	// Stop wins over start when both land together
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			enable_r <= 1'b0;
		end else if (channelStopBit) begin
			enable_r <= 1'b0;
		end else if (channelStartBit) begin
			enable_r <= 1'b1;
		end
	end

	// Settings latch only while stopped, so a frame never changes rate midway
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_r <= '{divider: DIV_RESET, preSel: PRE_RESET, invertOut: 1'b0,
				contMode: 1'b0, parityEn: 1'b0};
		end else if (!enable_r) begin
			cfg_r <= cfgIn;
			if (cfgIn.divider < DIV_MIN) begin
				cfg_r.divider <= DIV_MIN;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !enable_r) begin
			preCnt_r <= '0;
		end else begin
			preCnt_r <= preCnt_r + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit path

	logic                    fifoValid;
	logic                    fifoPop;
	logic [FIFO_W-1:0]       fifoData;
	tx_state_t               txState_r;
	logic [BIT_CNT_W-1:0]    txCnt_r;
	logic [2:0]              txBit_r;
	logic [DATA_W-1:0]       txShift_r;
	logic                    txTick;

	sync_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) txFifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (txWrite),
		.inReady  (txReady),
		.inData   (FIFO_W'(txData)),
		.outValid (fifoValid),
		.outReady (fifoPop),
		.outData  (fifoData)
	);

	assign txTick = mckEn && (txCnt_r == bitPeriod - 1'b1);
	assign fifoPop = enable_r && fifoValid &&
		(txState_r == TX_IDLE || (txState_r == TX_STOP && txTick));

	always_ff @(posedge clk) begin
		if (!rst_n || !enable_r || fifoPop) begin
			txCnt_r <= '0;
		end else if (mckEn) begin
			txCnt_r <= txTick ? '0 : txCnt_r + 1'b1;
		end
	end

	// Frame: start, 8 data LSB first, one stop; no parity on send
	always_ff @(posedge clk) begin
		if (!rst_n || !enable_r) begin
			txState_r <= TX_IDLE;
			txBit_r   <= '0;
			txShift_r <= '0;
		end else begin
			if (fifoPop) begin
				txState_r <= TX_START;
				txShift_r <= fifoData[DATA_W-1:0];
			end else if (txTick) begin
				case (txState_r)
					TX_START: begin
						txState_r <= TX_DATA;
						txBit_r   <= '0;
					end
					TX_DATA: begin
						txShift_r <= {1'b0, txShift_r[DATA_W-1:1]};
						txBit_r   <= txBit_r + 1'b1;
						if (txBit_r == 3'h7) begin
							txState_r <= TX_STOP;
						end
					end
					TX_STOP: txState_r <= TX_IDLE;
					default: txState_r <= TX_IDLE;
				endcase
			end
		end
	end

	// Pin idles at the phase level, also while stopped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			serialTxPin <= 1'b1;
		end else begin
			case (txState_r)
				TX_START: serialTxPin <= cfg_r.invertOut;
				TX_DATA:  serialTxPin <= txShift_r[0] ^ cfg_r.invertOut;
				default:  serialTxPin <= !cfg_r.invertOut;
			endcase
		end
	end

	// Single mode: end of stop bit; continuous: buffer handed to the shifter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			transmitIrq <= 1'b0;
		end else if (cfg_r.contMode) begin
			transmitIrq <= fifoPop;
		end else begin
			transmitIrq <= enable_r && txState_r == TX_STOP && txTick;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive path

	rx_state_t               rxState_r;
	logic [BIT_CNT_W-1:0]    rxCnt_r;
	logic [2:0]              rxBit_r;
	logic [DATA_W-1:0]       rxShift_r;
	logic                    rxPar_r;
	logic                    rxTick;
	logic                    rxLine;
	logic                    rxDone;
	logic [ERR_W-1:0]        errSet;
	logic [ERR_W-1:0]        errFlags_r;
	logic                    bff_r;

	assign rxLine = serialRxPin ^ cfg_r.invertOut;
	assign rxTick = mckEn && (rxCnt_r == bitPeriod - 1'b1);
	assign rxDone = rxTick && rxState_r == RX_STOP;

	always_ff @(posedge clk) begin
		if (!rst_n || !enable_r || rxState_r == RX_IDLE) begin
			rxCnt_r <= {1'b0, bitPeriod[BIT_CNT_W-1:1]};
		end else if (mckEn) begin
			rxCnt_r <= rxTick ? '0 : rxCnt_r + 1'b1;
		end
	end

	// Sampling at mid-bit; no parity bit in the frame, parityEn flags odd data
	always_ff @(posedge clk) begin
		if (!rst_n || !enable_r) begin
			rxState_r <= RX_IDLE;
			rxBit_r   <= '0;
			rxShift_r <= '0;
			rxPar_r   <= 1'b0;
		end else begin
			case (rxState_r)
				RX_IDLE: begin
					if (!rxLine) begin
						rxState_r <= RX_START;
					end
				end
				RX_START: begin
					if (rxTick) begin
						rxState_r <= rxLine ? RX_IDLE : RX_DATA;
						rxBit_r   <= '0;
						rxPar_r   <= 1'b0;
					end
				end
				RX_DATA: begin
					if (rxTick) begin
						rxPar_r   <= rxPar_r ^ rxLine;
						rxShift_r <= {rxLine, rxShift_r[DATA_W-1:1]};
						rxBit_r   <= rxBit_r + 1'b1;
						if (rxBit_r == 3'h7) begin
							rxState_r <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rxTick) begin
						rxState_r <= RX_IDLE;
					end
				end
				default: rxState_r <= RX_IDLE;
			endcase
		end
	end

	// Error causes for the finishing word
	always_comb begin
		errSet = '0;
		if (rxDone) begin
			errSet[ERR_FRAMING] = !rxLine;
			errSet[ERR_OVERRUN] = bff_r && !dataRead;
			errSet[ERR_PARITY]  = cfg_r.parityEn && rxPar_r;
		end
	end

	// Read-out empties the buffer so a word ending meanwhile is no overrun
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bff_r          <= 1'b0;
			channelDataReg <= '0;
		end else if (rxDone && !(bff_r && !dataRead)) begin
			bff_r          <= 1'b1;
			channelDataReg <= rxShift_r;
		end else if (dataRead) begin
			bff_r <= 1'b0;
		end
	end

	// New error beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			errFlags_r <= '0;
		end else if (flagClearWrite) begin
			errFlags_r <= (errFlags_r & ~flagClearValue) | errSet;
		end else begin
			errFlags_r <= errFlags_r | errSet;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			channelStatusReg <= '0;
		end else begin
			channelStatusReg.txBusy         <= fifoValid || txState_r != TX_IDLE;
			channelStatusReg.bufferFullFlag <= bff_r;
			channelStatusReg.errFlags       <= errFlags_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence sLastStop;
		txState_r == TX_STOP && txTick && enable_r;
	endsequence

	sequence sLoad;
		fifoPop ##1 txState_r == TX_START;
	endsequence

	a_read_clears_bff: assert property (dataRead && !rxDone |=> !bff_r ##1
		!channelStatusReg.bufferFullFlag) else $error("read left buffer full");
	a_clear_frame: assert property (flagClearWrite && flagClearValue[ERR_FRAMING]
		&& !errSet[ERR_FRAMING] |=> !errFlags_r[ERR_FRAMING])
		else $error("framing flag not cleared");
	a_keep_uncleared: assert property (flagClearWrite && !flagClearValue[ERR_PARITY]
		&& errFlags_r[ERR_PARITY] |=> errFlags_r[ERR_PARITY])
		else $error("parity flag lost");
	a_stop_disables: assert property (channelStopBit |=> !channelEnableStatusBit
		##1 txState_r == TX_IDLE) else $error("stop did not halt");
	a_start_enables: assert property (channelStartBit && !channelStopBit
		|=> channelEnableStatusBit) else $error("start did not enable");
	a_start_level: assert property (sLoad |=> serialTxPin == cfg_r.invertOut)
		else $error("start bit level wrong");
	// Pin is registered from the phase bit, so it trails a phase change by a cycle
	a_idle_level: assert property (!enable_r && !$past(enable_r)
		|-> serialTxPin == !$past(cfg_r.invertOut)) else $error("idle level wrong");
	a_irq_single: assert property (!cfg_r.contMode ##0 sLastStop |=> transmitIrq)
		else $error("missing end interrupt");
	a_irq_cont: assert property (cfg_r.contMode && fifoPop |=> transmitIrq)
		else $error("missing empty interrupt");
	a_cfg_frozen: assert property (enable_r && $past(enable_r) |-> $stable(cfg_r))
		else $error("settings changed while running");
	a_div_min: assert property (cfg_r.divider >= DIV_MIN)
		else $error("divider below minimum");

endmodule // uart_lin_tx
`default_nettype wire

// ---- bench/lin_slave_model.sv ----
// Purpose: LIN slave node seen through a transceiver: decodes and sends frames
// Assumes: Fixed bit time in clocks; bus pulled high when released
// Notes:   Decoder aborts when the start bit is gone at mid-bit
`timescale 1ns/100ps
`default_nettype none
module lin_slave_model #(
	parameter int BIT_T = 18
) (
	input  wire logic clk,
	input  wire logic busLine,
	input  wire logic invert,
	output wire logic rxLine
);
	logic [8:0] got [$];
	logic [8:0] frm;
	logic       lineOut;
	int         lowRun = 0;
	int         lastLow = 0;
	// Reply follows the channel phase, else an inverted receiver sees a break
	assign rxLine = lineOut ^ invert;
	initial lineOut = 1'b1;
	////////////////////////////////////////////////////////////////////////////
	// Low run of the bus, for break width checks
	always @(negedge clk) begin
		if ((busLine ^ invert) === 1'b0) begin
			lowRun++;
		end else begin
			if (lowRun != 0) lastLow = lowRun;
			lowRun = 0;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	always begin
		@(negedge clk);
		if ((busLine ^ invert) === 1'b0) begin
			repeat (BIT_T / 2) @(negedge clk);
			if ((busLine ^ invert) === 1'b0) begin
				for (int i = 0; i < 9; i++) begin
					repeat (BIT_T) @(negedge clk);
					frm[i] = busLine ^ invert;
				end
				got.push_back(frm);
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic send_byte(input logic [7:0] d, input logic stopLvl);
		logic [9:0] f;
		f = {stopLvl, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk);
			lineOut = f[i];
			repeat (BIT_T - 1) @(negedge clk);
		end
		@(negedge clk);
		lineOut = 1'b1;
		repeat (BIT_T) @(negedge clk);
	endtask
endmodule // lin_slave_model
`default_nettype wire

// ---- bench/tb_uart_error_recovery_lin_tx.sv ----
// Purpose: Self-checking bench for the serial channel with LIN send
// Assumes: Normal bit time 18 clocks (divider 8, preSel 0)
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/100ps
`default_nettype none
module tb_uart_error_recovery_lin_tx import lin_tx_pkg::*; ;
	localparam int BT   = 18;
	localparam int CEIL = 40000;
	logic                clk, rst_n, txWrite, txReady, dataRead, flagClearWrite;
	logic                channelStopBit, channelStartBit, channelEnableStatusBit;
	logic                transmitIrq, serialTxPin, serialRxPin, mInv;
	logic [DATA_W-1:0]   txData, channelDataReg;
	logic [ERR_W-1:0]    flagClearValue;
	channel_status_t     channelStatusReg;
	channel_cfg_t        cfgIn, cfgActive;
	int                  mismatches = 0, comparisons = 0, cycles = 0, irqCount = 0;
	int                  n, i, k;

	uart_lin_tx u_uart_lin_tx (.clk(clk), .rst_n(rst_n), .txWrite(txWrite),
		.txData(txData), .txReady(txReady), .dataRead(dataRead),
		.channelDataReg(channelDataReg), .channelStatusReg(channelStatusReg),
		.flagClearWrite(flagClearWrite), .flagClearValue(flagClearValue),
		.channelStopBit(channelStopBit), .channelStartBit(channelStartBit),
		.channelEnableStatusBit(channelEnableStatusBit), .cfgIn(cfgIn),
		.cfgActive(cfgActive), .transmitIrq(transmitIrq),
		.serialTxPin(serialTxPin), .serialRxPin(serialRxPin));
	lin_slave_model #(.BIT_T(BT)) u_lin_slave_model (.clk(clk), .busLine(serialTxPin),
		.invert(mInv), .rxLine(serialRxPin));
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (transmitIrq === 1'b1) irqCount++;
		if (cycles == CEIL) begin
			mismatches++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic ctl(input logic stp, input logic str);
		@(negedge clk);
		channelStopBit = stp;
		channelStartBit = str;
		@(negedge clk);
		channelStopBit = 1'b0;
		channelStartBit = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	// Settings only land while stopped, so stop, set, start
	task automatic setup(input logic [DIV_W-1:0] d, input logic inv);
		ctl(1'b1, 1'b0);
		cfgIn.divider = d;
		cfgIn.invertOut = inv;
		repeat (2) @(negedge clk);
		mInv = inv;
		ctl(1'b0, 1'b1);
	endtask
	task automatic send(input logic [7:0] d);
		@(negedge clk);
		for (i = 0; i < 200 && txReady !== 1'b1; i++) @(negedge clk);
		txData = d;
		txWrite = 1'b1;
		@(negedge clk);
		txWrite = 1'b0;
	endtask
	task automatic wait_frames(input int cnt);
		for (i = 0; i < cnt * 400 && u_lin_slave_model.got.size() < cnt; i++) @(negedge clk);
		repeat (BT) @(negedge clk);
	endtask
	task automatic clr(input logic [ERR_W-1:0] v);
		@(negedge clk);
		flagClearValue = v;
		flagClearWrite = 1'b1;
		@(negedge clk);
		flagClearWrite = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic rd();
		@(negedge clk);
		dataRead = 1'b1;
		@(negedge clk);
		dataRead = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk(serialTxPin === 1'b1, "idle level");
		chk(channelEnableStatusBit === 1'b0, "enable at reset");
		chk(cfgActive.divider === DIV_RESET, "divider at reset");
		chk(channelStatusReg === '0, "status at reset");
		setup(7'h01, 1'b0);
		chk(cfgActive.divider === DIV_MIN, "divider clamp");
		chk(channelEnableStatusBit === 1'b1, "started");
		setup(7'h08, 1'b0);
		cfgIn.divider = 7'h14;
		repeat (3) @(negedge clk);
		chk(cfgActive.divider === 7'h08, "running cfg held");
		cfgIn.divider = 7'h08;
		$display("test reset_config done");
	endtask
	task automatic t_send();
		u_lin_slave_model.got.delete();
		n = irqCount;
		send(8'hA5);
		send(8'h80);
		wait_frames(2);
		chk(u_lin_slave_model.got[0] === 9'h1A5, "frame A5");
		chk(u_lin_slave_model.got[1] === 9'h180, "wake-up 80");
		chk(irqCount === n + 2, "irq per byte");
		$display("test send done");
	endtask
	task automatic t_break();
		setup(7'h0C, 1'b0);
		n = irqCount;
		send(8'h00);
		for (k = 0; k < 2000 && irqCount == n; k++) @(negedge clk);
		chk(irqCount === n + 1, "irq after break");
		chk(u_lin_slave_model.lastLow >= 13 * BT - 3 && u_lin_slave_model.lastLow <= 13 * BT + 3,
			"break width");
		repeat (300) @(negedge clk);
		u_lin_slave_model.got.delete();
		setup(7'h08, 1'b0);
		send(8'h55);
		wait_frames(1);
		chk(u_lin_slave_model.got[0] === 9'h155, "sync after break");
		$display("test break done");
	endtask
	task automatic t_invert();
		setup(7'h08, 1'b1);
		chk(serialTxPin === 1'b0, "inverted idle");
		u_lin_slave_model.got.delete();
		send(8'h3C);
		wait_frames(1);
		chk(u_lin_slave_model.got[0] === 9'h13C, "inverted frame");
		setup(7'h08, 1'b0);
		$display("test invert done");
	endtask
	task automatic t_rx();
		u_lin_slave_model.send_byte(8'h5A, 1'b0);
		repeat (4) @(negedge clk);
		chk(channelDataReg === 8'h5A, "word on framing");
		chk(channelStatusReg.errFlags === 3'b100, "framing flag");
		rd();
		chk(channelStatusReg.bufferFullFlag === 1'b0, "read clears full");
		clr(channelStatusReg.errFlags);
		chk(channelStatusReg.errFlags === 3'b000, "clear read value");
		ctl(1'b1, 1'b0);
		chk(channelEnableStatusBit === 1'b0, "stopped");
		u_lin_slave_model.got.delete();
		send(8'hC3);
		repeat (12 * BT) @(negedge clk);
		chk(u_lin_slave_model.got.size() == 0 && serialTxPin === 1'b1, "halted");
		chk(channelStatusReg.txBusy === 1'b1, "byte held while stopped");
		ctl(1'b0, 1'b1);
		chk(channelEnableStatusBit === 1'b1, "restarted");
		wait_frames(1);
		chk(u_lin_slave_model.got[0] === 9'h1C3, "send after start");
		u_lin_slave_model.send_byte(8'h07, 1'b1);
		u_lin_slave_model.send_byte(8'h11, 1'b1);
		repeat (4) @(negedge clk);
		chk(channelStatusReg.errFlags === 3'b011, "parity and overrun");
		chk(channelDataReg === 8'h07, "overrun keeps word");
		clr(3'b010);
		chk(channelStatusReg.errFlags === 3'b001, "clear only overrun");
		rd();
		clr(3'b001);
		$display("test rx_errors done");
	endtask
	task automatic t_fifo();
		cfgIn.contMode = 1'b1;
		ctl(1'b1, 1'b0);
		u_lin_slave_model.got.delete();
		for (k = 0; k < 40 && txReady === 1'b1; k++) begin
			txData = k[7:0];
			txWrite = 1'b1;
			@(negedge clk);
		end
		txWrite = 1'b0;
		chk(k == FIFO_DEPTH, "fifo depth");
		n = irqCount;
		ctl(1'b0, 1'b1);
		wait_frames(FIFO_DEPTH);
		for (k = 0; k < FIFO_DEPTH; k++) begin
			chk(u_lin_slave_model.got[k] === {1'b1, k[7:0]}, "fifo order");
		end
		chk(u_lin_slave_model.got.size() == FIFO_DEPTH, "frame count");
		chk(irqCount === n + FIFO_DEPTH, "irq per pop");
		$display("test fifo done");
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		txWrite = 1'b0;
		txData = '0;
		dataRead = 1'b0;
		flagClearWrite = 1'b0;
		flagClearValue = '0;
		channelStopBit = 1'b0;
		channelStartBit = 1'b0;
		mInv = 1'b0;
		cfgIn = '0;
		cfgIn.divider = DIV_RESET;
		cfgIn.parityEn = 1'b1;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_reset();
		t_send();
		t_break();
		t_invert();
		t_rx();
		t_fifo();
		print_verdict();
	end
endmodule // tb_uart_error_recovery_lin_tx
`default_nettype wire
